// *** hw/pmic_irq_pkg.sv ***
package pmic_irq_pkg;

  // clock rate and the power key hold time
  localparam int CLOCK_HZ = 20_000_000;
  localparam int PUSH_HOLD_US = 5000;
  // least time in cycles, clock rate truncated to whole MHz
  localparam int PUSH_HOLD_CYCLES = (PUSH_HOLD_US * (CLOCK_HZ / 1_000_000) * 1 + 0);
  localparam int KEY_CNT_W = 20;

  // i2c target address, bit 4 is the factory option, left at 0
  localparam logic [6:0] TARGET_ADDR = 7'h61;

  // identity values: arbitrary, not tied to any real part
  localparam logic [4:0] PART_CODE = 5'h0b;
  localparam logic [2:0] REVISION_CODE = 3'h3;

  // register offsets
  localparam logic [7:0] ADDR_IDENTITY = 8'h00;
  localparam logic [7:0] ADDR_SUMMARY = 8'h01;
  localparam logic [7:0] ADDR_SYS_FLAGS = 8'h02;
  localparam logic [7:0] ADDR_SYS_MASK = 8'h03;
  localparam logic [7:0] ADDR_CHG_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_CHG_MASK = 8'h05;
  localparam logic [7:0] ADDR_RAIL_FLAGS = 8'h06;
  localparam logic [7:0] ADDR_RAIL_MASK = 8'h07;

  // flag banks: system, charger, rail
  localparam int NUM_BANKS = 3;
  localparam int BANK_SYS = 0;
  localparam int BANK_CHG = 1;
  localparam int BANK_RAIL = 2;
  localparam logic [2:0][7:0] BANK_FLAG_ADDR = {ADDR_RAIL_FLAGS, ADDR_CHG_FLAGS, ADDR_SYS_FLAGS};
  localparam logic [2:0][7:0] BANK_MASK_ADDR = {ADDR_RAIL_MASK, ADDR_CHG_MASK, ADDR_SYS_MASK};
  localparam logic [2:0][7:0] BANK_MASK_RESET = {8'hff, 8'h7f, 8'h3f};
  localparam logic [2:0][7:0] BANK_USED_BITS = {8'h0f, 8'h7f, 8'h3f};
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // summary bit positions
  localparam int SUM_SYS_BIT = 3;
  localparam int SUM_CHG_BIT = 2;
  localparam int SUM_BUCK_BIT = 1;
  localparam int SUM_LDO_BIT = 0;
  localparam logic [3:0] SUMMARY_RESET = 4'h0;

  // system flag bit positions
  localparam int SYS_KEY_BIT = 5;
  localparam int SYS_WARM_BIT = 4;
  localparam int SYS_OVERHEAT_BIT = 3;
  localparam int SYS_SUPPLY_BIT = 2;
  localparam int SYS_WDOG_BIT = 1;
  localparam int SYS_INPWR_BIT = 0;

  // i2c engine states
  typedef enum logic [3:0] {
    I2C_IDLE,
    I2C_ADDR,
    I2C_ADDR_ACK,
    I2C_REG,
    I2C_REG_ACK,
    I2C_WDATA,
    I2C_WDATA_ACK,
    I2C_RDATA,
    I2C_RDATA_ACK
  } i2c_state_e;

endpackage

// *** hw/flag_bank_if.sv ***
`timescale 1ns/1ns
`default_nettype none
// one flag register with its mask, between the top and a bank
interface flag_bank_if;
  logic [7:0] events;   // one-cycle set requests
  logic wr_clear;       // write-one-to-clear strobe
  logic wr_mask;        // mask write strobe
  logic [7:0] wr_data;  // data of either write
  logic [7:0] flags;    // latched flags
  logic [7:0] mask;     // mask, 1 blocks
  logic [7:0] active;   // flags that pass the mask
  modport owner(output events, wr_clear, wr_mask, wr_data, input flags, mask, active);
  modport bank(input events, wr_clear, wr_mask, wr_data, output flags, mask, active);
endinterface
`default_nettype wire

// *** hw/event_flag_bank.sv ***
`timescale 1ns/1ns
`default_nettype none
module event_flag_bank #(
  parameter logic [7:0] MASK_RESET = 8'hff,
  parameter logic [7:0] USED_BITS = 8'hff
) (
  input wire logic clock,
  input wire logic rst_n,
  flag_bank_if.bank bus
);

  typedef struct packed {
    logic [7:0] flags; // latched events
    logic [7:0] mask;  // per-bit block
  } bank_s;

  bank_s st_reg;
  bank_s st_next;
  logic [7:0] clear_bits; // bits written with one

  // set wins over clear so an event in the clear cycle survives
  always_comb begin
    st_next = st_reg;
    clear_bits = bus.wr_clear ? bus.wr_data : 8'h00;
    st_next.flags = ((st_reg.flags & ~clear_bits) | bus.events) & USED_BITS;
    if (bus.wr_mask) begin
      st_next.mask = bus.wr_data;
    end
  end

  // state register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{flags: pmic_irq_pkg::FLAGS_RESET, mask: MASK_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus.flags = st_reg.flags;
  assign bus.mask = st_reg.mask;
  assign bus.active = st_reg.flags & ~st_reg.mask;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_EVENT_LATCHES: assert property ((bus.events & USED_BITS) != 8'h00 |=>
    (st_reg.flags & $past(bus.events & USED_BITS)) == $past(bus.events & USED_BITS))
    else $error("event not latched");
  AST_ZERO_KEEPS: assert property (bus.wr_clear |=>
    ((st_reg.flags & $past(st_reg.flags & ~bus.wr_data)) == $past(st_reg.flags & ~bus.wr_data)))
    else $error("flag written with zero was lost");
  AST_ONE_CLEARS: assert property (bus.wr_clear && (bus.events & bus.wr_data) == 8'h00 |=>
    (st_reg.flags & $past(bus.wr_data)) == 8'h00)
    else $error("flag written with one not cleared");
  AST_MASK_STORES: assert property (bus.wr_mask |=> st_reg.mask == $past(bus.wr_data) ##1
    (bus.wr_mask || st_reg.mask == $past(st_reg.mask)))
    else $error("mask write not kept");
  COV_SET_AND_CLEAR: cover property (bus.wr_clear && (bus.events & bus.wr_data) != 8'h00);

endmodule
`default_nettype wire

// *** hw/pmic_interrupt_aggregator.sv ***
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - identity register holds part and revision codes
// - events latch; first unmasked one pulls irq low
// - repeat of set flag changes nothing
// - several events set all flags, one assertion
// - summary groups system, charger, buck, ldo bits
// - group bit clears when all group flags clear
// - summary read-only, bits seven to four zero
// - unmasked system flag sets system group bit
// - flag registers are write-one-to-clear
// - key low past hold time sets bit five
// - temperature at warning threshold sets bit four
// - temperature at shutdown threshold sets bit three
// - low supply below pre-warning sets bit two
// - watchdog expiry sets bit one
// - input power status change sets bit zero
// - mask one blocks, resets ones; reserved bits store writes, rail mask resets ff
// - unmasked charger flag sets charger group bit
// - ones clear flags, zeros leave them alone
// - i2c target, auto-increment wraps, no stretching
// - rail flags feed buck and ldo group bits
module pmic_interrupt_aggregator #(
  parameter int PUSH_HOLD_CYCLES = pmic_irq_pkg::PUSH_HOLD_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic irq_out_n,
  input wire logic power_key_n,
  input wire logic [1:0] warn_threshold_sel,
  input wire logic [2:0] shutdown_threshold_sel,
  input wire logic [3:0] temp_warn_cmp,
  input wire logic [7:0] temp_shdn_cmp,
  input wire logic supply_low_warn,
  input wire logic watchdog_expired,
  input wire logic input_power_ok,
  input wire logic [3:0] charger_timer_events,
  input wire logic [2:0] charger_status_ok,
  input wire logic [3:0] rail_ok
);

  localparam logic [pmic_irq_pkg::KEY_CNT_W-1:0] HOLD_CNT = pmic_irq_pkg::KEY_CNT_W'(PUSH_HOLD_CYCLES);

  typedef struct packed {
    logic [2:0] scl_sync; // pin synchroniser, [0] first
    logic scl_f;          // agreed scl level
    logic [2:0] sda_sync; // pin synchroniser
    logic sda_f;          // agreed sda level
    logic [2:0] key_sync; // power key synchroniser
    logic key_f;          // agreed key level
    pmic_irq_pkg::i2c_state_e state;
    logic [3:0] bit_cnt;  // bits of the current byte
    logic [7:0] shift;    // received byte
    logic [7:0] tx;       // byte being sent
    logic [7:0] ptr;      // register pointer
    logic rw;             // read transfer
    logic nack;           // host refused more data
    logic oe;             // pulling sda low
    logic wr_en;          // one-cycle register write
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [pmic_irq_pkg::KEY_CNT_W-1:0] key_cnt; // low time of the key
    logic pwr_prev;       // last input power status
    logic [2:0] chg_prev; // last charger status
    logic [3:0] rail_prev; // last rail good status
    logic [3:0] summary;  // group bits
    logic irq_n;          // registered interrupt line
  } top_s;

  top_s st_reg;
  top_s st_next;
  logic [1:0] rst_pipe; // reset release synchroniser
  logic rst_n;          // released reset used everywhere
  logic [2:0][7:0] bank_events;
  logic [2:0][7:0] bank_flags;
  logic [2:0][7:0] bank_mask;
  logic [2:0][7:0] bank_active;
  logic [3:0] summary_now; // group bits from current flags
  logic [7:0] rd_data;    // register at the pointer
  logic key_event;        // key held long enough
  logic scl_new;
  logic sda_new;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // reset asserts at once and releases after two edges
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // flag banks, one per register pair
  flag_bank_if bank_bus [pmic_irq_pkg::NUM_BANKS] ();
  for (genvar g = 0; g < pmic_irq_pkg::NUM_BANKS; g++) begin : g_bank
    assign bank_bus[g].events = bank_events[g];
    assign bank_bus[g].wr_clear = st_reg.wr_en && st_reg.wr_addr == pmic_irq_pkg::BANK_FLAG_ADDR[g];
    assign bank_bus[g].wr_mask = st_reg.wr_en && st_reg.wr_addr == pmic_irq_pkg::BANK_MASK_ADDR[g];
    assign bank_bus[g].wr_data = st_reg.wr_data;
    assign bank_flags[g] = bank_bus[g].flags;
    assign bank_mask[g] = bank_bus[g].mask;
    assign bank_active[g] = bank_bus[g].active;
    event_flag_bank #(
      .MASK_RESET(pmic_irq_pkg::BANK_MASK_RESET[g]),
      .USED_BITS(pmic_irq_pkg::BANK_USED_BITS[g])
    ) u_bank (
      .clock(clock),
      .rst_n(rst_n),
      .bus(bank_bus[g])
    );
  end

  // key event fires once, the cycle the low time reaches the hold count
  assign key_event = !st_reg.key_f && st_reg.key_cnt == HOLD_CNT - 1'b1;

  // event sources into the three banks
  always_comb begin
    bank_events = '0;
    bank_events[pmic_irq_pkg::BANK_SYS][pmic_irq_pkg::SYS_KEY_BIT] = key_event;
    bank_events[pmic_irq_pkg::BANK_SYS][pmic_irq_pkg::SYS_WARM_BIT] =
      temp_warn_cmp[warn_threshold_sel];
    bank_events[pmic_irq_pkg::BANK_SYS][pmic_irq_pkg::SYS_OVERHEAT_BIT] =
      temp_shdn_cmp[shutdown_threshold_sel];
    bank_events[pmic_irq_pkg::BANK_SYS][pmic_irq_pkg::SYS_SUPPLY_BIT] = supply_low_warn;
    bank_events[pmic_irq_pkg::BANK_SYS][pmic_irq_pkg::SYS_WDOG_BIT] = watchdog_expired;
    bank_events[pmic_irq_pkg::BANK_SYS][pmic_irq_pkg::SYS_INPWR_BIT] =
      input_power_ok != st_reg.pwr_prev;
    // charger: timer and limit pulses on top, status changes below
    bank_events[pmic_irq_pkg::BANK_CHG][6:3] = charger_timer_events;
    bank_events[pmic_irq_pkg::BANK_CHG][2:0] = charger_status_ok ^ st_reg.chg_prev;
    // rails: buck outputs in [3:2], ldo outputs in [1:0]
    bank_events[pmic_irq_pkg::BANK_RAIL][3:0] = rail_ok ^ st_reg.rail_prev;
  end

  // group bits follow the unmasked flags, so each clears with its last flag
  always_comb begin
    summary_now = pmic_irq_pkg::SUMMARY_RESET;
    summary_now[pmic_irq_pkg::SUM_SYS_BIT] = |bank_active[pmic_irq_pkg::BANK_SYS];
    summary_now[pmic_irq_pkg::SUM_CHG_BIT] = |bank_active[pmic_irq_pkg::BANK_CHG];
    summary_now[pmic_irq_pkg::SUM_BUCK_BIT] = |bank_active[pmic_irq_pkg::BANK_RAIL][3:2];
    summary_now[pmic_irq_pkg::SUM_LDO_BIT] = |bank_active[pmic_irq_pkg::BANK_RAIL][1:0];
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    unique case (st_reg.ptr)
      pmic_irq_pkg::ADDR_IDENTITY: rd_data = {pmic_irq_pkg::PART_CODE, pmic_irq_pkg::REVISION_CODE};
      pmic_irq_pkg::ADDR_SUMMARY: rd_data = {4'h0, st_reg.summary};
      pmic_irq_pkg::ADDR_SYS_FLAGS: rd_data = bank_flags[pmic_irq_pkg::BANK_SYS];
      pmic_irq_pkg::ADDR_SYS_MASK: rd_data = bank_mask[pmic_irq_pkg::BANK_SYS];
      pmic_irq_pkg::ADDR_CHG_FLAGS: rd_data = bank_flags[pmic_irq_pkg::BANK_CHG];
      pmic_irq_pkg::ADDR_CHG_MASK: rd_data = bank_mask[pmic_irq_pkg::BANK_CHG];
      pmic_irq_pkg::ADDR_RAIL_FLAGS: rd_data = bank_flags[pmic_irq_pkg::BANK_RAIL];
      pmic_irq_pkg::ADDR_RAIL_MASK: rd_data = bank_mask[pmic_irq_pkg::BANK_RAIL];
      default: rd_data = 8'h00;
    endcase
  end

  // filtered pin levels and bus conditions
  assign scl_new = (st_reg.scl_sync[1] == st_reg.scl_sync[2]) ? st_reg.scl_sync[2] : st_reg.scl_f;
  assign sda_new = (st_reg.sda_sync[1] == st_reg.sda_sync[2]) ? st_reg.sda_sync[2] : st_reg.sda_f;
  assign scl_rise = scl_new && !st_reg.scl_f;
  assign scl_fall = !scl_new && st_reg.scl_f;
  assign bus_start = st_reg.scl_f && scl_new && st_reg.sda_f && !sda_new;
  assign bus_stop = st_reg.scl_f && scl_new && !st_reg.sda_f && sda_new;

  // next state: synchronisers, key timer, i2c target engine
  always_comb begin
    st_next = st_reg;
    st_next.wr_en = 1'b0;
    // three-stage pin sampling, first stage read only by the second
    st_next.scl_sync = {st_reg.scl_sync[1:0], scl_in};
    st_next.sda_sync = {st_reg.sda_sync[1:0], sda_in};
    st_next.key_sync = {st_reg.key_sync[1:0], power_key_n};
    st_next.scl_f = scl_new;
    st_next.sda_f = sda_new;
    if (st_reg.key_sync[1] == st_reg.key_sync[2]) begin
      st_next.key_f = st_reg.key_sync[2];
    end
    // key low time, held at the count so one press gives one event
    if (st_reg.key_f) begin
      st_next.key_cnt = '0;
    end else if (st_reg.key_cnt != HOLD_CNT) begin
      st_next.key_cnt = st_reg.key_cnt + 1'b1;
    end
    // status history for change detection
    st_next.pwr_prev = input_power_ok;
    st_next.chg_prev = charger_status_ok;
    st_next.rail_prev = rail_ok;
    // line stays low from the first unmasked event until all groups clear
    st_next.summary = summary_now;
    st_next.irq_n = ~|summary_now;
    // i2c engine; sda only changes after scl falls, never stretches scl
    if (bus_start) begin
      st_next.state = pmic_irq_pkg::I2C_ADDR;
      st_next.bit_cnt = 4'h0;
      st_next.oe = 1'b0;
    end else if (bus_stop) begin
      st_next.state = pmic_irq_pkg::I2C_IDLE;
      st_next.oe = 1'b0;
    end else begin
      unique case (st_reg.state)
        pmic_irq_pkg::I2C_IDLE: begin
          st_next.oe = 1'b0;
        end
        pmic_irq_pkg::I2C_ADDR, pmic_irq_pkg::I2C_REG, pmic_irq_pkg::I2C_WDATA: begin
          if (scl_rise) begin
            st_next.shift = {st_reg.shift[6:0], st_reg.sda_f};
            st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
          end else if (scl_fall && st_reg.bit_cnt == 4'h8) begin
            st_next.bit_cnt = 4'h0;
            st_next.oe = 1'b1;
            if (st_reg.state == pmic_irq_pkg::I2C_ADDR) begin
              // a foreign address sends us back to idle without acknowledge
              if (st_reg.shift[7:1] == pmic_irq_pkg::TARGET_ADDR) begin
                st_next.rw = st_reg.shift[0];
                st_next.state = pmic_irq_pkg::I2C_ADDR_ACK;
              end else begin
                st_next.oe = 1'b0;
                st_next.state = pmic_irq_pkg::I2C_IDLE;
              end
            end else if (st_reg.state == pmic_irq_pkg::I2C_REG) begin
              st_next.ptr = st_reg.shift;
              st_next.state = pmic_irq_pkg::I2C_REG_ACK;
            end else begin
              // write to the pointer, then step it; 8-bit pointer wraps
              st_next.wr_en = 1'b1;
              st_next.wr_addr = st_reg.ptr;
              st_next.wr_data = st_reg.shift;
              st_next.ptr = st_reg.ptr + 1'b1;
              st_next.state = pmic_irq_pkg::I2C_WDATA_ACK;
            end
          end
        end
        pmic_irq_pkg::I2C_ADDR_ACK: begin
          if (scl_fall) begin
            if (st_reg.rw) begin
              // first read byte comes from the current pointer
              st_next.tx = rd_data;
              st_next.ptr = st_reg.ptr + 1'b1;
              st_next.oe = !rd_data[7];
              st_next.state = pmic_irq_pkg::I2C_RDATA;
            end else begin
              st_next.oe = 1'b0;
              st_next.state = pmic_irq_pkg::I2C_REG;
            end
          end
        end
        pmic_irq_pkg::I2C_REG_ACK, pmic_irq_pkg::I2C_WDATA_ACK: begin
          if (scl_fall) begin
            st_next.oe = 1'b0;
            st_next.state = pmic_irq_pkg::I2C_WDATA;
          end
        end
        pmic_irq_pkg::I2C_RDATA: begin
          if (scl_rise) begin
            st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
          end else if (scl_fall) begin
            if (st_reg.bit_cnt == 4'h8) begin
              st_next.oe = 1'b0;
              st_next.bit_cnt = 4'h0;
              st_next.state = pmic_irq_pkg::I2C_RDATA_ACK;
            end else begin
              st_next.tx = {st_reg.tx[6:0], 1'b0};
              st_next.oe = !st_reg.tx[6];
            end
          end
        end
        pmic_irq_pkg::I2C_RDATA_ACK: begin
          if (scl_rise) begin
            st_next.nack = st_reg.sda_f;
          end else if (scl_fall) begin
            if (st_reg.nack) begin
              st_next.state = pmic_irq_pkg::I2C_IDLE;
            end else begin
              st_next.tx = rd_data;
              st_next.ptr = st_reg.ptr + 1'b1;
              st_next.oe = !rd_data[7];
              st_next.state = pmic_irq_pkg::I2C_RDATA;
            end
          end
        end
      endcase
    end
  end

  // state register; idle bus levels and released line after reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{
        scl_sync: 3'h7, scl_f: 1'b1, sda_sync: 3'h7, sda_f: 1'b1,
        key_sync: 3'h7, key_f: 1'b1, state: pmic_irq_pkg::I2C_IDLE,
        bit_cnt: 4'h0, shift: 8'h00, tx: 8'h00, ptr: 8'h00, rw: 1'b0,
        nack: 1'b0, oe: 1'b0, wr_en: 1'b0, wr_addr: 8'h00, wr_data: 8'h00,
        key_cnt: '0, pwr_prev: 1'b0, chg_prev: 3'h0, rail_prev: 4'h0,
        summary: pmic_irq_pkg::SUMMARY_RESET, irq_n: 1'b1
      };
    end else begin
      st_reg <= st_next;
    end
  end

  // open drain: level is always low, only the enable moves
  assign sda_out = 1'b0;
  assign sda_oe = st_reg.oe;
  assign irq_out_n = st_reg.irq_n;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_IRQ_ON_EVENT: assert property (summary_now != 4'h0 |=> !irq_out_n)
    else $error("unmasked event did not pull irq low");
  AST_IRQ_SINGLE: assert property (!irq_out_n && summary_now != 4'h0 |=> !irq_out_n)
    else $error("irq released while groups pending");
  AST_IRQ_RELEASE: assert property (summary_now == 4'h0 |=> irq_out_n)
    else $error("irq not released after groups cleared");
  AST_SYS_GROUP: assert property (bank_active[0] != 8'h00 |=> st_reg.summary[3])
    else $error("system group bit missing");
  AST_CHG_GROUP: assert property (bank_active[1] != 8'h00 |=> st_reg.summary[2])
    else $error("charger group bit missing");
  AST_GROUP_FALL: assert property ($fell(st_reg.summary[3]) |-> $past(bank_active[0]) == 8'h00)
    else $error("system group cleared with flags pending");
  AST_RAIL_GROUPS: assert property (bank_active[2][3:2] != 2'h0 |=> st_reg.summary[1])
    else $error("buck group bit missing");
  AST_KEY_HOLD: assert property (key_event |=> bank_flags[0][5] && st_reg.key_cnt == HOLD_CNT)
    else $error("key event timing wrong");
  AST_WDOG_FLAG: assert property (watchdog_expired |=> bank_flags[0][1])
    else $error("watchdog flag not set");
  AST_PWR_CHANGE: assert property ($changed(input_power_ok) |-> ##1 bank_flags[0][0])
    else $error("input power change not flagged");
  AST_IDENTITY: assert property (st_reg.ptr == 8'h00 |-> rd_data[2:0] == 3'h3 && rd_data[7:3] == 5'h0b)
    else $error("identity value wrong");
  AST_SUMMARY_RO: assert property (st_reg.ptr == 8'h01 |-> rd_data[7:4] == 4'h0 ##1
    (st_reg.wr_en || st_reg.summary == $past(summary_now)))
    else $error("summary reserved bits or value wrong");
  COV_IRQ: cover property ($fell(irq_out_n));
  COV_READ_ACK: cover property (st_reg.state == pmic_irq_pkg::I2C_RDATA_ACK && scl_fall && !st_reg.nack);
  COV_KEY: cover property (key_event);
  COV_WRITE: cover property (st_reg.wr_en && st_reg.wr_addr == 8'h02);

endmodule
`default_nettype wire

// *** testbench/i2c_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// host side of the two-wire bus; open drain, so it only ever pulls sda low
module i2c_host_model (
  input wire logic clock,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_low
);
  logic [7:0] rx; // last byte read back
  logic acked; // target answer to the last byte
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // wait n clocks, then step off the edge by the usual small delay
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #5;
  endtask
  // sda moves only well after scl low, past the target's filter delay
  task automatic bit_io(input logic b, output logic s);
    tick(5);
    sda_low = ~b;
    tick(10);
    scl = 1'b1;
    tick(10);
    s = sda_wire;
    scl = 1'b0;
  endtask
  // eight bits msb first, then the ninth for the answer
  task automatic xfer(input logic [7:0] tx, input logic host_ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(~host_ack, s);
    acked = ~s;
  endtask
  // start or repeated start: sda falls while scl high
  task automatic start();
    tick(5);
    sda_low = 1'b0;
    tick(5);
    scl = 1'b1;
    tick(10);
    sda_low = 1'b1;
    tick(10);
    scl = 1'b0;
  endtask
  // stop: sda rises while scl high
  task automatic stop();
    tick(5);
    sda_low = 1'b1;
    tick(10);
    scl = 1'b1;
    tick(10);
    sda_low = 1'b0;
    tick(10);
  endtask
endmodule
`default_nettype wire

// *** testbench/pmic_interrupt_aggregator_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module pmic_interrupt_aggregator_bench;
  logic clock, reset_n, sda_oe, irq_n, scl, sda_low;
  logic key_n, low_warn, wdog, pwr_ok, sda_drv;
  logic [1:0] warn_sel;
  logic [2:0] shdn_sel, chg_ok;
  logic [3:0] warn_cmp, rail, chg_tmr;
  logic [7:0] shdn_cmp;
  localparam logic [7:0] ID = {pmic_irq_pkg::PART_CODE, pmic_irq_pkg::REVISION_CODE};
  localparam logic [7:0] WA = {pmic_irq_pkg::TARGET_ADDR, 1'b0};
  int errors = 0, comparisons = 0;
  // wire is pulled up unless someone pulls it low
  wire logic sda_wire = ~(sda_low | sda_oe);
  i2c_host_model h(.clock(clock), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));
  // short key hold keeps the run brief
  pmic_interrupt_aggregator #(.PUSH_HOLD_CYCLES(20)) DUT(.clock(clock), .reset_n(reset_n), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_drv), .sda_oe(sda_oe), .irq_out_n(irq_n), .power_key_n(key_n),
    .warn_threshold_sel(warn_sel), .shutdown_threshold_sel(shdn_sel), .temp_warn_cmp(warn_cmp),
    .temp_shdn_cmp(shdn_cmp), .supply_low_warn(low_warn), .watchdog_expired(wdog), .input_power_ok(pwr_ok),
    .charger_timer_events(chg_tmr), .charger_status_ok(chg_ok), .rail_ok(rail));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic results();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // register write: address, offset, one data byte
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    h.start();
    h.xfer(WA, 1'b0);
    `CHK(h.acked, 1'b1)
    h.xfer(a, 1'b0);
    h.xfer(v, 1'b0);
    h.stop();
  endtask
  // register read; cur skips the offset and reads at the pointer
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic cur = 1'b0);
    h.start();
    if (!cur) begin
      h.xfer(WA, 1'b0);
      h.xfer(a, 1'b0);
      h.start();
    end
    h.xfer(WA | 8'h01, 1'b0);
    h.xfer(8'hff, 1'b0); // refuse the byte so the target lets go before stop
    `CHK(h.rx, exp)
    h.stop();
  endtask
  // hang guard
  initial begin
    repeat (60000) @(posedge clock);
    errors++;
    results();
  end
  initial begin
    reset_n = 1'b0;
    key_n = 1'b1;
    {low_warn, wdog, pwr_ok, warn_sel, shdn_sel, chg_ok} = 11'h000;
    {warn_cmp, rail, chg_tmr, shdn_cmp} = 20'h00000;
    repeat (4) @(posedge clock);
    #5 reset_n = 1'b1;
    h.tick(6);
    rd(8'h00, ID);
    `CHK(sda_drv, 1'b0)
    rd(8'h00, 8'h00, 1'b1);
    rd(8'hff, 8'h00);
    rd(8'h00, ID, 1'b1);
    rd(8'h03, 8'h3f);
    // masked event latches yet stays quiet
    wdog = 1'b1;
    h.tick(1);
    wdog = 1'b0;
    h.tick(4);
    `CHK(irq_n, 1'b1)
    rd(8'h02, 8'h02);
    wr(8'h03, 8'h00);
    `CHK(irq_n, 1'b0)
    low_warn = 1'b1;
    wdog = 1'b1;
    h.tick(1);
    low_warn = 1'b0;
    wdog = 1'b0;
    rd(8'h02, 8'h06);
    wr(8'h01, 8'hff);
    rd(8'h01, 8'h08);
    wr(8'h02, 8'h02);
    rd(8'h02, 8'h04);
    `CHK(irq_n, 1'b0)
    wr(8'h02, 8'h04);
    rd(8'h01, 8'h00);
    `CHK(irq_n, 1'b1)
    // a short press and comparators off the selected threshold count for nothing
    warn_sel = 2'h2;
    shdn_sel = 3'h5;
    warn_cmp = 4'hb;
    shdn_cmp = 8'hdf;
    key_n = 1'b0;
    h.tick(10);
    key_n = 1'b1;
    rd(8'h02, 8'h00);
    key_n = 1'b0;
    warn_cmp = 4'h4;
    shdn_cmp = 8'h20;
    pwr_ok = 1'b1;
    h.tick(40);
    key_n = 1'b1;
    warn_cmp = 4'h0;
    shdn_cmp = 8'h00;
    rd(8'h02, 8'h39);
    `CHK(irq_n, 1'b0)
    wr(8'h02, 8'hff);
    wr(8'h05, 8'h00);
    wr(8'h07, 8'h00);
    chg_ok = 3'h1;
    rail = 4'h9;
    rd(8'h04, 8'h01);
    rd(8'h06, 8'h09);
    rd(8'h01, 8'h07);
    wr(8'h05, 8'h7f);
    rd(8'h01, 8'h03);
    // masked charger timer pulse still latches
    chg_tmr = 4'h8;
    h.tick(1);
    chg_tmr = 4'h0;
    rd(8'h04, 8'h41);
    rd(8'h01, 8'h03);
    results();
  end
endmodule
`default_nettype wire
